//--- sldn_ctl_model.sv
`default_nettype none
module sldn_ctl_model (
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic [7:0] want_i,
  output logic [3:0]      high_digit_lines_o,
  output logic [3:0]      units_o,
  output logic            ref_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ref_cnt;
  // ****
  // reference: one pulse every 160 clocks, the locked sample rate
  // ****
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ref_cnt <= 8'h00;
      ref_o <= 1'b0;
    end else begin
      ref_cnt <= (ref_cnt == 8'h9F) ? 8'h00 : ref_cnt + 8'h01;
      ref_o <= (ref_cnt == 8'h9F);
    end
  end
  // out-of-range nibbles clamp to nine so only legal codes leave the unit
  always_ff @(posedge clock_i) begin
    high_digit_lines_o <= (want_i[7:4] > 4'h9) ? 4'h9 : want_i[7:4];
    units_o <= (want_i[3:0] > 4'h9) ? 4'h9 : want_i[3:0];
  end
endmodule
`default_nettype wire

//--- sldn_pkg.sv
`default_nettype none

package sldn_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_KHZ         = 40000;
  localparam int FIN_MIN_KHZ     = 15250;
  localparam int FIN_MAX_KHZ     = 40000;
  localparam int SAMPLE_KHZ      = 250;
  localparam int WINDOW_US       = 1000;
  localparam int LOCKIN_KHZ      = 10;
  localparam int ACQ_TYPICAL_MS  = 5;
  localparam int SWEEP_HALF_MS   = 10;
  localparam int WINDOW_CYC      = WINDOW_US * (CLK_KHZ / 1000);
  localparam int SWEEP_HALF_CYC  = SWEEP_HALF_MS * CLK_KHZ;
  localparam int DIFF_LIMIT      = (LOCKIN_KHZ * WINDOW_US) / 1000;

  // ************************************************************
  // divider stages
  // ************************************************************
  localparam logic [3:0] DEC_LAST   = 4'h9;
  localparam logic [3:0] HEX_LAST   = 4'hF;
  localparam logic [3:0] ARM_UNITS  = 4'h5;
  localparam logic [3:0] ARM_HIGH_DIGIT_LINES   = 4'hF;
  localparam logic [3:0] STAGE_RST  = 4'h0;

  // preset counter, gray from idle through the four loads; the return to idle flips two bits
  typedef enum logic [2:0] {
    PS_IDLE  = 3'h0,
    PS_LOAD1 = 3'h1,
    PS_LOAD2 = 3'h3,
    PS_LOAD3 = 3'h2,
    PS_LOAD4 = 3'h6
  } sldn_preset_e;

  // ************************************************************
  // register port
  // ************************************************************
  localparam logic [1:0] REG_CTRL    = 2'h0;
  localparam logic [1:0] REG_STATUS  = 2'h1;
  localparam logic [1:0] REG_RATIO   = 2'h2;
  localparam logic [1:0] REG_DIFFCNT = 2'h3;
  localparam int CTRL_SWEEP_BIT      = 0;
  localparam int ST_UNLOCK_BIT       = 0;
  localparam int ST_FAULT_BIT        = 1;
  localparam int ST_HIGH_BIT         = 2;
  localparam int ST_LOW_BIT          = 3;
  localparam logic [7:0] RDATA_RST   = 8'h00;

endpackage

`default_nettype wire

//--- sldn_top.sv
`default_nettype none


module sldn_top #(
  parameter int WINDOW_CYC     = sldn_pkg::WINDOW_CYC,
  parameter int SWEEP_HALF_CYC = sldn_pkg::SWEEP_HALF_CYC
) (
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic [3:0] units_digit_i,
  input  wire logic [3:0] high_digit_lines_i,
  input  wire logic       ref_pulse_i,
  input  wire logic [1:0] other_unlock_i,
  input  wire logic [1:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o,
  output logic            sample_o,
  output logic            unlock_o,
  output logic            lock_fault_o,
  output logic            tune_high_o,
  output logic            tune_low_o
);

  // ************************************************************
  // divider state
  // ************************************************************
  // clock_i is the shaped input already inverted, so its rising
  // edge is the trailing edge of the mixed-down oscillator
  logic [3:0]             dec_stage;
  logic [3:0]             hex_stage;
  logic [3:0]             next_dec;
  logic [3:0]             next_hex;
  sldn_pkg::sldn_preset_e preset_state;
  sldn_pkg::sldn_preset_e next_preset;
  logic                   preset_stage_last_out;
  logic [7:0]             loaded_ratio;

  wire terminal_count_decode;
  wire count_stage_gate;
  wire dec_wrap;
  wire load_now;

  // decode is blocked once the preset counter leaves idle
  assign terminal_count_decode = (preset_state == sldn_pkg::PS_IDLE)
                                 && (dec_stage == sldn_pkg::ARM_UNITS)
                                 && (hex_stage == sldn_pkg::ARM_HIGH_DIGIT_LINES);
  assign count_stage_gate = (preset_state == sldn_pkg::PS_IDLE);
  assign dec_wrap = (dec_stage == sldn_pkg::DEC_LAST);
  assign load_now = terminal_count_decode;

  // ************************************************************
  // preset counter
  // ************************************************************
  // four load states give the preload time to settle before counting
  always_comb begin
    case (preset_state)
      sldn_pkg::PS_IDLE: begin
        next_preset = terminal_count_decode ? sldn_pkg::PS_LOAD1
                                            : sldn_pkg::PS_IDLE;
      end
      sldn_pkg::PS_LOAD1: begin
        next_preset = sldn_pkg::PS_LOAD2;
      end
      sldn_pkg::PS_LOAD2: begin
        next_preset = sldn_pkg::PS_LOAD3;
      end
      sldn_pkg::PS_LOAD3: begin
        next_preset = sldn_pkg::PS_LOAD4;
      end
      sldn_pkg::PS_LOAD4: begin
        next_preset = sldn_pkg::PS_IDLE;
      end
      default: begin
        next_preset = sldn_pkg::PS_IDLE;
      end
    endcase
  end

  // ************************************************************
  // count stages
  // ************************************************************
  // the one terminal compare picks load over count for every next value, which keeps the path
  // short enough for the top of the input band
  always_comb begin
    next_dec = dec_stage;
    next_hex = hex_stage;
    if (load_now) begin
      // units feed the decade, high_digit_lines the sixteen stage; 8-4-2-1 lines
      next_dec = units_digit_i;
      next_hex = high_digit_lines_i;
    end else if (count_stage_gate) begin
      if (dec_wrap) begin
        next_dec = sldn_pkg::STAGE_RST;
        next_hex = (hex_stage == sldn_pkg::HEX_LAST) ? sldn_pkg::STAGE_RST
                                                     : hex_stage + 4'h1;
      end else begin
        next_dec = dec_stage + 4'h1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      dec_stage    <= sldn_pkg::STAGE_RST;
      hex_stage    <= sldn_pkg::STAGE_RST;
      preset_state <= sldn_pkg::PS_IDLE;
    end else begin
      dec_stage    <= next_dec;
      hex_stage    <= next_hex;
      preset_state <= next_preset;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      preset_stage_last_out <= 1'b0;
    end else begin
      // one pulse per divide cycle, period 160 minus preload
      preset_stage_last_out <= (next_preset == sldn_pkg::PS_LOAD1);
    end
  end

  // readback keeps the digits really loaded, not those on the lines
  // now, so a change between two loads reaches software only at the next load
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      loaded_ratio <= 8'h00;
    end else if (load_now) begin
      loaded_ratio <= {high_digit_lines_i, units_digit_i};
    end
  end

  assign sample_o = preset_stage_last_out;

  // ************************************************************
  // lock loss detector
  // ************************************************************
  logic                   ref_armed;
  logic                   samp_armed;
  logic                   dir_high;
  logic                   unlock;
  logic [15:0]            win_cnt;
  logic [7:0]             diff_cnt;
  logic                   saw_ref;
  logic                   saw_samp;
  logic                   test_sweep;
  logic                   sweep_dir;
  logic [19:0]            sweep_cnt;

  wire both_edges;
  wire ref_fast;
  wire samp_fast;
  wire diff_pulse;
  wire win_end;
  wire diff_over;
  wire sweep_turn;

  // a second reference with no sample between means the sample is
  // slow, and the reverse means it is fast
  assign both_edges = ref_pulse_i && preset_stage_last_out;
  assign ref_fast   = ref_pulse_i && ref_armed && !both_edges;
  assign samp_fast  = preset_stage_last_out && samp_armed && !both_edges;
  assign diff_pulse = ref_fast || samp_fast;
  assign win_end    = (win_cnt == 16'(WINDOW_CYC - 1));
  assign diff_over  = (diff_cnt > 8'(sldn_pkg::DIFF_LIMIT));
  assign sweep_turn = (sweep_cnt == 20'(SWEEP_HALF_CYC - 1));

  // a coincident pair disarms both sides, so neither counts as a slip
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || both_edges) begin
      ref_armed <= 1'b0;
    end else begin
      ref_armed <= ref_pulse_i || (ref_armed && !preset_stage_last_out);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i || both_edges) begin
      samp_armed <= 1'b0;
    end else begin
      samp_armed <= preset_stage_last_out || (samp_armed && !ref_pulse_i);
    end
  end

  // ************************************************************
  // difference integrator and comparator
  // ************************************************************
  // the comparator trips at the loop lock-in range; a window with no
  // reference or no sample at all also counts as unlocked
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      win_cnt  <= 16'h0000;
      diff_cnt <= 8'h00;
      saw_ref  <= 1'b0;
      saw_samp <= 1'b0;
      unlock   <= 1'b1;
    end else if (win_end) begin
      win_cnt  <= 16'h0000;
      diff_cnt <= 8'h00;
      saw_ref  <= 1'b0;
      saw_samp <= 1'b0;
      unlock   <= diff_over || !saw_ref || !saw_samp;
    end else begin
      win_cnt  <= win_cnt + 16'h0001;
      if (diff_pulse && (diff_cnt != 8'hFF)) begin
        diff_cnt <= diff_cnt + 8'h01;
      end
      saw_ref  <= saw_ref || ref_pulse_i;
      saw_samp <= saw_samp || preset_stage_last_out;
      if (diff_over) begin
        unlock <= 1'b1;
      end
    end
  end

  // ************************************************************
  // coarse tune steering
  // ************************************************************
  // the window is well under the typical acquisition time, so the
  // sweep is lifted soon after the loop comes into capture range;
  // the direction keeps its last verdict while no slips arrive, so
  // steering does not flutter between windows
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      dir_high <= 1'b0;
    end else if (ref_fast) begin
      dir_high <= 1'b1;
    end else if (samp_fast) begin
      dir_high <= 1'b0;
    end
  end

  // the counter is held clear while test sweep is off, so every sweep
  // starts with a full half period high
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !test_sweep) begin
      sweep_cnt <= 20'h00000;
      sweep_dir <= 1'b1;
    end else if (sweep_turn) begin
      sweep_cnt <= 20'h00000;
      sweep_dir <= !sweep_dir;
    end else begin
      sweep_cnt <= sweep_cnt + 20'h00001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      tune_high_o <= 1'b0;
      tune_low_o  <= 1'b0;
    end else if (test_sweep) begin
      tune_high_o <= sweep_dir;
      tune_low_o  <= !sweep_dir;
    end else begin
      tune_high_o <= unlock && dir_high;
      tune_low_o  <= unlock && !dir_high;
    end
  end

  // the lamp is combinational so a fault of another loop shows at once
  assign unlock_o     = unlock;
  assign lock_fault_o = unlock || (|other_unlock_i);

  // ************************************************************
  // register port
  // ************************************************************
  wire       wr_ctrl;
  wire [7:0] status_val;
  wire [7:0] ctrl_val;
  logic [7:0] rd_mux;

  assign wr_ctrl    = wr_i && (addr_i == sldn_pkg::REG_CTRL);
  assign ctrl_val   = {7'h00, test_sweep};
  assign status_val = {4'h0, tune_low_o, tune_high_o, lock_fault_o, unlock};

  always_comb begin
    case (addr_i)
      sldn_pkg::REG_CTRL: begin
        rd_mux = ctrl_val;
      end
      sldn_pkg::REG_STATUS: begin
        rd_mux = status_val;
      end
      sldn_pkg::REG_RATIO: begin
        rd_mux = loaded_ratio;
      end
      sldn_pkg::REG_DIFFCNT: begin
        rd_mux = diff_cnt;
      end
      default: begin
        rd_mux = sldn_pkg::RDATA_RST;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      test_sweep <= 1'b0;
    end else if (wr_ctrl) begin
      test_sweep <= wdata_i[sldn_pkg::CTRL_SWEEP_BIT];
    end
  end

  // read data fall back to zero between reads, so a stale word never
  // looks like an answer
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rdata_o <= sldn_pkg::RDATA_RST;
    end else begin
      rdata_o <= rd_i ? rd_mux : sldn_pkg::RDATA_RST;
    end
  end

endmodule

`default_nettype wire

//--- sldn_top_chk.sv
`default_nettype none
module sldn_top_chk #(
  parameter int WINDOW_CYC     = 2000,
  parameter int SWEEP_HALF_CYC = 50
) (
  input wire logic       clock_i,
  input wire logic       reset_n_i,
  input wire logic [3:0] units_digit_i,
  input wire logic [3:0] high_digit_lines_i,
  input wire logic       ref_pulse_i,
  input wire logic [1:0] other_unlock_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       sample_o,
  input wire logic       unlock_o,
  input wire logic       lock_fault_o,
  input wire logic       tune_high_o,
  input wire logic       tune_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  logic [7:0] exp_p;
  logic [7:0] dq;
  logic       armed;
  logic       sweep;
  // ****
  // gap tracker: digits present at the load edge fix the next gap
  // ****
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cnt <= 8'h00;
      armed <= 1'b0;
      sweep <= 1'b0;
      exp_p <= 8'hA0;
      dq <= 8'h00;
    end else begin
      dq <= {high_digit_lines_i, units_digit_i};
      cnt <= sample_o ? 8'h01 : cnt + 8'h01;
      if (sample_o) begin
        armed <= 1'b1;
        exp_p <= 8'hA0 - 8'h0A * {4'h0, dq[7:4]} - {4'h0, dq[3:0]};
      end
      if (wr_i && addr_i == sldn_pkg::REG_CTRL) begin
        sweep <= wdata_i[sldn_pkg::CTRL_SWEEP_BIT];
      end
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_quiet; (!sample_o) [*8]; endsequence
  sequence s_calm; !unlock_o && !sweep; endsequence
  property p_fault; lock_fault_o == (unlock_o || (|other_unlock_i)); endproperty
  a_fault: assert property (p_fault) else $error("lamp is not the or of unlocks");
  property p_quiet; sample_o |=> s_quiet; endproperty
  a_quiet: assert property (p_quiet) else $error("sample pulses too close");
  property p_period; sample_o && armed |-> cnt == exp_p; endproperty
  a_period: assert property (p_period) else $error("sample gap wrong");
  property p_gap; cnt <= 8'hA0; endproperty
  a_gap: assert property (p_gap) else $error("no sample within full count");
  property p_apart; !(tune_high_o && tune_low_o); endproperty
  a_apart: assert property (p_apart) else $error("both steering outputs on");
  property p_calm; s_calm ##1 s_calm |-> !tune_high_o && !tune_low_o; endproperty
  a_calm: assert property (p_calm) else $error("steering while locked");
  property p_sweep; sweep && $rose(tune_high_o) |=> (tune_high_o || !sweep) [*7]; endproperty
  a_sweep: assert property (p_sweep) else $error("sweep half too short");
  property p_status;
    rd_i && addr_i == sldn_pkg::REG_STATUS |=>
      rdata_o[sldn_pkg::ST_UNLOCK_BIT] == $past(unlock_o);
  endproperty
  a_status: assert property (p_status) else $error("status unlock bit wrong");
endmodule
bind sldn_top sldn_top_chk #(
  .WINDOW_CYC    (WINDOW_CYC),
  .SWEEP_HALF_CYC(SWEEP_HALF_CYC)
) sldn_top_chk_inst (.*);
`default_nettype wire

//--- sldn_top_tb_top.sv
`default_nettype none
module sldn_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock_i, reset_n_i, ref_pulse_i, wr_i, rd_i, rd_seen, hi, lo;
  logic       sample_o, unlock_o, lock_fault_o, tune_high_o, tune_low_o;
  logic [3:0] units_digit_i, high_digit_lines_i;
  logic [1:0] other_unlock_i, addr_i;
  logic [7:0] want, wdata_i, rdata_o, per_cnt, d;
  logic [7:0] rd_q[$];
  logic [7:0] per_q[$];
  logic [31:0] seed;
  logic [7:0] tbl[5] = '{8'h99, 8'h00, 8'h09, 8'h90, 8'h55};
  int         fail_count, n_tests;
  sldn_top #(.WINDOW_CYC(2000), .SWEEP_HALF_CYC(50)) sldn_top_inst (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .units_digit_i(units_digit_i),
    .high_digit_lines_i(high_digit_lines_i), .ref_pulse_i(ref_pulse_i),
    .other_unlock_i(other_unlock_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .sample_o(sample_o), .unlock_o(unlock_o),
    .lock_fault_o(lock_fault_o), .tune_high_o(tune_high_o), .tune_low_o(tune_low_o));
  sldn_ctl_model sldn_ctl_model_inst (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .want_i(want), .high_digit_lines_o(high_digit_lines_i), .units_o(units_digit_i),
    .ref_o(ref_pulse_i));
  always #12.5 clock_i = ~clock_i;
  // ****
  // shared tasks
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus_wr(input logic [1:0] a, input logic [7:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic bus_rd(input logic [1:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // read data stands only in the cycle after the strobe; gaps end at each sample
  always @(posedge clock_i) begin
    if (rd_seen) check("rdata", rd_q.pop_front(), rdata_o);
    rd_seen = rd_i;
    if (sample_o) begin
      if (per_q.size() > 0) check("gap", per_q.pop_front(), per_cnt);
      per_cnt = 8'h01;
    end else per_cnt = per_cnt + 8'h01;
  end
  initial begin
    #1000000;
    fail_count++;
    results();
  end
  initial begin
    {clock_i, reset_n_i, wr_i, rd_i, rd_seen, addr_i, wdata_i, other_unlock_i} = '0;
    want = 8'h00;
    per_cnt = 8'h00;
    seed = 32'h00001161;
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    #1 check("unlock", 8'h01, {7'h00, unlock_o});
    @(posedge clock_i);
    repeat (6000) @(posedge clock_i);
    #1 check("unlock", 8'h00, {7'h00, unlock_o});
    @(posedge clock_i);
    other_unlock_i <= 2'h2;
    @(posedge clock_i);
    #1 check("fault", 8'h01, {7'h00, lock_fault_o});
    @(posedge clock_i);
    other_unlock_i <= 2'h0;
    @(posedge clock_i);
    bus_rd(sldn_pkg::REG_STATUS, 8'h00);
    bus_wr(sldn_pkg::REG_STATUS, 8'hFF);
    bus_rd(sldn_pkg::REG_STATUS, 8'h00);
    bus_rd(sldn_pkg::REG_RATIO, 8'h00);
    bus_rd(sldn_pkg::REG_DIFFCNT, 8'h00);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      d = (i < 5) ? tbl[i] : {4'(seed[15:8] % 8'h0A), 4'(seed[23:16] % 8'h0A)};
      @(posedge clock_i iff sample_o);
      want <= d;
      other_unlock_i <= seed[1:0];
      @(posedge clock_i iff sample_o);
      #1 per_q.push_back(8'hA0 - 8'h0A * {4'h0, d[7:4]} - {4'h0, d[3:0]});
    end
    @(posedge clock_i iff sample_o);
    want <= 8'h99;
    other_unlock_i <= 2'h0;
    repeat (6000) @(posedge clock_i);
    #1 check("steer", 8'h03, {6'h00, unlock_o, tune_low_o});
    @(posedge clock_i);
    bus_rd(sldn_pkg::REG_STATUS, 8'h0B);
    bus_rd(sldn_pkg::REG_RATIO, 8'h99);
    bus_wr(sldn_pkg::REG_CTRL, 8'h01);
    bus_rd(sldn_pkg::REG_CTRL, 8'h01);
    {hi, lo} = 2'h0;
    repeat (200) begin
      @(posedge clock_i);
      hi |= tune_high_o;
      lo |= tune_low_o;
    end
    check("sweep", 8'h03, {6'h00, hi, lo});
    bus_wr(sldn_pkg::REG_CTRL, 8'h00);
    repeat (4) @(posedge clock_i);
    results();
  end
endmodule
`default_nettype wire
